// ===== design/ddrwl_core.sv
`timescale 1ns/1ps
module ddrwl_core
(
  // clock and reset
  input  wire logic                  core_clk,
  input  wire logic                  rstn,
  // apb slave
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [7:0]            paddr,
  input  wire logic [31:0]           pwdata,
  output logic                       pready,
  output logic [31:0]                prdata,
  output logic                       pslverr,
  // dram pins from controller
  input  wire logic                  ck,
  input  wire logic                  cke,
  input  wire logic                  odt,
  input  wire ddrwl_pkg::ddrwl_cmd_t cmd_in,
  input  wire logic [1:0]            dqs,
  // dq drive and termination
  output ddrwl_pkg::ddrwl_pins_t     pins,
  output logic                       rtt_dq_on
);

  // ***************************************
  // input synchronisers
  // ***************************************
  logic [1:0] ck_s1, ck_s2, cke_s1, cke_s2, odt_s1, odt_s2;
  logic [1:0] dqs_s1, dqs_s2, dqs_s3;
  logic [22:0] cmd_s1, cmd_s2;
  logic        ck_lvl, ck_prev;

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      ck_s1  <= 2'h0;
      ck_s2  <= 2'h0;
      cke_s1 <= 2'h0;
      cke_s2 <= 2'h0;
      odt_s1 <= 2'h0;
      odt_s2 <= 2'h0;
      dqs_s1 <= 2'h0;
      dqs_s2 <= 2'h0;
      dqs_s3 <= 2'h0;
      cmd_s1 <= 23'h7f_ffff;
      cmd_s2 <= 23'h7f_ffff;
      ck_prev <= 1'b0;
    end
    else
    begin
      ck_s1  <= {1'b0, ck};
      ck_s2  <= ck_s1;
      cke_s1 <= {1'b0, cke};
      cke_s2 <= cke_s1;
      odt_s1 <= {1'b0, odt};
      odt_s2 <= odt_s1;
      dqs_s1 <= dqs;
      dqs_s2 <= dqs_s1;
      dqs_s3 <= dqs_s2;
      cmd_s1 <= cmd_in;
      cmd_s2 <= cmd_s1;
      ck_prev <= ck_s2[0];
    end
  end

  // commands are latched on sampled ck rising edges
  wire                   ck_rise = ck_s2[0] & ~ck_prev;
  wire ddrwl_pkg::ddrwl_cmd_t cmd = cmd_s2;
  wire                   cke_l   = cke_s2[0];
  wire                   odt_l   = odt_s2[0];
  wire [1:0]             dqs_rise = dqs_s2 & ~dqs_s3;
  wire                   is_mrs  = ck_rise & cke_l & (cmd.cmd == ddrwl_pkg::CMD_MRS);
  wire                   mrs0    = is_mrs & (cmd.ba == 3'h0);
  wire                   mrs1    = is_mrs & (cmd.ba == 3'h1);
  // self refresh entry {cs,ras,cas low, we high} with cke falling
  wire                   sref_cmd = ck_rise & (cmd.cmd == 4'h1);

  // ***************************************
  // mode register and power state
  // ***************************************
  logic [15:0] mr0_reg, mr1_reg;
  logic        sref_reg, pdn_reg, cke_prev_reg;

  // power-state entry is a ck-edge event: cke was high at the last rise, low now
  wire         cke_drop = ck_rise & cke_prev_reg & ~cke_l;

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      mr0_reg      <= ddrwl_pkg::MR_RST;
      mr1_reg      <= ddrwl_pkg::MR_RST;
      sref_reg     <= 1'b0;
      pdn_reg      <= 1'b0;
      cke_prev_reg <= 1'b0;
    end
    else
    begin
      if (ck_rise)
        cke_prev_reg <= cke_l;
      // write leveling follows MR1 A7; output disable follows A12
      if (mrs1)
        mr1_reg <= cmd.addr;
      if (mrs0)
        mr0_reg <= cmd.addr;
      // self refresh: clock ignored until cke returns
      if (cke_drop & sref_cmd)
        sref_reg <= 1'b1;
      else if (cke_l)
        sref_reg <= 1'b0;
      // any other cke drop at a ck rise is power-down
      if (cke_drop & ~sref_cmd)
        pdn_reg <= 1'b1;
      else if (cke_l)
        pdn_reg <= 1'b0;
    end
  end

  wire wlvl   = mr1_reg[ddrwl_pkg::MR1_WLVL];
  wire qoff   = mr1_reg[ddrwl_pkg::MR1_QOFF];
  wire rtt_nom_en = mr1_reg[ddrwl_pkg::MR1_RTT0] | mr1_reg[ddrwl_pkg::MR1_RTT1]
                  | mr1_reg[ddrwl_pkg::MR1_RTT2];
  wire dll_on = ~mr1_reg[ddrwl_pkg::MR1_DLL_DIS];

  // ***************************************
  // write leveling feedback
  // ***************************************
  logic [1:0]  sample_reg;
  logic [1:0]  sampled_reg;
  logic        all_dq_reg;

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      sample_reg  <= 2'h0;
      sampled_reg <= 2'h0;
    end
    else if (!wlvl)
    begin
      sample_reg  <= 2'h0;
      sampled_reg <= 2'h0;
    end
    else
    begin
      // per byte lane, own strobe catches ck level
      for (int i = 0; i < 2; i++)
      begin
        if (dqs_rise[i])
        begin
          sample_reg[i]  <= ck_s2[0];
          sampled_reg[i] <= 1'b1;
        end
      end
    end
  end

  // ***************************************
  // pin drive and termination
  // ***************************************
  ddrwl_pkg::ddrwl_pins_t pins_next;
  logic                   rtt_dq_next;

  always_comb
  begin
    pins_next = '0;
    for (int i = 0; i < 2; i++)
    begin
      // outputs disabled when qoff is set
      if (wlvl & ~qoff & sampled_reg[i])
      begin
        pins_next.dq_oe[i*8 +: 8] = 8'hff;
        // non-prime bits driven low after first sample unless ctrl selects all-dq feedback
        pins_next.dq_o[i*8 +: 8]  = all_dq_reg ? {8{sample_reg[i]}} : {7'h00, sample_reg[i]};
      end
      // odt switches only strobe termination in leveling
      pins_next.rtt_dqs_on[i] = wlvl & odt_l & rtt_nom_en;
    end
    // data termination off in leveling; in power-down and self refresh forced off
    rtt_dq_next = ~wlvl & odt_l & rtt_nom_en & cke_l & ~sref_reg;
  end

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      pins      <= '0;
      rtt_dq_on <= 1'b0;
    end
    else
    begin
      pins      <= pins_next;
      rtt_dq_on <= rtt_dq_next;
    end
  end

  // ***************************************
  // apb slave
  // ***************************************
  logic [31:0] ctrl_reg;
  wire         acc    = psel & penable & ~pready;
  wire         hit_ct = paddr == ddrwl_pkg::OFF_CTRL;
  wire         hit_st = paddr == ddrwl_pkg::OFF_STATUS;
  wire         hit_m0 = paddr == ddrwl_pkg::OFF_MR0;
  wire         hit_m1 = paddr == ddrwl_pkg::OFF_MR1;
  wire         mapped = hit_ct | hit_st | hit_m0 | hit_m1;
  wire [31:0]  status = {22'h0, sample_reg, 3'h0, dll_on, qoff, pdn_reg, sref_reg, wlvl};
  wire [31:0]  rd_mux = hit_ct ? ctrl_reg
                      : hit_st ? status
                      : hit_m0 ? {16'h0, mr0_reg}
                      : hit_m1 ? {16'h0, mr1_reg} : 32'h0;

  assign all_dq_reg = ctrl_reg[ddrwl_pkg::CTRL_ALL_DQ];

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      ctrl_reg <= ddrwl_pkg::CTRL_RST;
      pready   <= 1'b0;
      prdata   <= 32'h0;
      pslverr  <= 1'b0;
    end
    else
    begin
      pready  <= acc;
      pslverr <= acc & ~mapped;
      if (acc & ~pwrite)
        prdata <= rd_mux;
      if (acc & pwrite & hit_ct)
        ctrl_reg <= {31'h0, pwdata[ddrwl_pkg::CTRL_ALL_DQ]};
    end
  end

endmodule : ddrwl_core

// ===== include/ddrwl_pkg.sv
// Summary of operation
// - device ignores clock in self refresh once tCKSRE elapsed.
// - power-down termination off: ODT low if nominal enabled, else forced off.
// - MR1 A7 written 1 enters write leveling, 0 leaves it.
// - MR1 A12 is output disable: 0 enables buffers, 1 disables.
// - in leveling ODT switches strobe termination only, data termination off.
// - device samples CK on strobe rising edge, drives it on DQ.
// - feedback on prime bit or all bits, others low; per byte lane.
package ddrwl_pkg;
  // apb map
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_MR0    = 8'h08;
  localparam logic [7:0] OFF_MR1    = 8'h0c;
  // ctrl fields
  localparam int CTRL_ALL_DQ = 0;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  // mode register bits
  localparam int MR1_DLL_DIS = 0;
  localparam int MR1_RTT0    = 2;
  localparam int MR1_WLVL    = 7;
  localparam int MR1_RTT1    = 6;
  localparam int MR1_RTT2    = 9;
  localparam int MR1_QOFF    = 12;
  localparam int MR0_DLL_RST = 8;
  localparam logic [15:0] MR_RST = 16'h0000;
  // command encoding {cs_n, ras_n, cas_n, we_n}
  localparam logic [3:0] CMD_MRS = 4'h0;
  // status fields
  localparam int ST_WLVL = 0;
  localparam int ST_SREF = 1;
  localparam int ST_PDN  = 2;
  localparam int ST_QOFF = 3;
  localparam int ST_DLL_ON = 4;
  localparam int ST_SAMPLE = 8;

  typedef struct packed {
    logic [3:0]  cmd;
    logic [2:0]  ba;
    logic [15:0] addr;
  } ddrwl_cmd_t;

  typedef struct packed {
    logic [1:0]  rtt_dqs_on;
    logic [15:0] dq_o;
    logic [15:0] dq_oe;
  } ddrwl_pins_t;
endpackage : ddrwl_pkg

// ===== verif/ddrwl_checker.sv
`timescale 1ns/1ps
// ****
// leveling checker
// ****
module ddrwl_checker (
  // clock, reset, apb
  input wire logic                   core_clk,
  input wire logic                   rstn,
  input wire logic                   psel,
  input wire logic                   penable,
  input wire logic                   pwrite,
  input wire logic [7:0]             paddr,
  input wire logic [31:0]            pwdata,
  input wire logic                   pready,
  input wire logic                   pslverr,
  // dram side
  input wire logic                   ck,
  input wire logic                   cke,
  input wire logic                   odt,
  input wire logic [1:0]             dqs,
  input wire ddrwl_pkg::ddrwl_cmd_t  cmd_in,
  input wire ddrwl_pkg::ddrwl_pins_t pins,
  input wire logic                   rtt_dq_on
);
  logic       ck_q, wl, qf, al, nom, l0;
  logic [3:0] n, pd;
  wire        mrs1 = ck && !ck_q && cke && cmd_in.cmd == ddrwl_pkg::CMD_MRS && cmd_in.ba == 3'h1;
  wire        st = n == 4'hf;
  wire        cw = psel && penable && pready && pwrite && paddr == ddrwl_pkg::OFF_CTRL;
  // settle count hides the sync and update lag after each MR1 write
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      {ck_q, wl, qf, al, nom, l0} <= 6'h0;
      {n, pd} <= 8'h0;
    end
    else
    begin
      ck_q <= ck;
      l0 <= $rose(dqs[0]) ? ck : l0;
      al <= cw ? pwdata[0] : al;
      pd <= cke ? 4'h0 : pd + {3'h0, pd != 4'hf};
      n <= mrs1 ? 4'h0 : n + {3'h0, !st};
      {qf, wl} <= mrs1 ? {cmd_in.addr[12], cmd_in.addr[7]} : {qf, wl};
      nom <= mrs1 ? |{cmd_in.addr[9], cmd_in.addr[6], cmd_in.addr[2]} : nom;
    end
  end
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rstn);
  a_dq_term_lvl:
    assert property (st && wl |-> !rtt_dq_on) else $error("dq termination on");
  a_dqs_term_odt:
    assert property (st && wl && $stable(odt) && odt == $past(odt, 6)
      |-> pins.rtt_dqs_on == {2{odt}}) else $error("strobe termination wrong");
  a_qoff_hiz:
    assert property (st && qf |-> pins.dq_oe == 16'h0) else $error("dq driven with qoff");
  a_prime_low:
    assert property (st && wl && !al && pins.dq_oe != 16'h0
      |-> {pins.dq_o[15:9], pins.dq_o[7:1]} == 14'h0) else $error("spare dq not low");
  a_sample_ck:
    assert property ($rose(dqs[0]) && st && wl && !qf && ck == $past(ck, 3)
      |-> ##[2:8] pins.dq_oe[0] && pins.dq_o[0] == l0) else $error("bad ck sample");
  a_pd_term:
    assert property (pd == 4'hf && !nom |-> !rtt_dq_on && pins.rtt_dqs_on == 2'h0)
      else $error("termination on in power-down");
  a_ready_pulse:
    assert property (pready |=> !pready) else $error("pready too long");
  a_unmapped_err:
    assert property (psel && penable && pready && paddr > 8'h0c |-> pslverr)
      else $error("no error on unmapped");
  cover property (st && wl && $rose(dqs[1]));
  cover property (pd == 4'hf);
  cover property (pready && pslverr);
endmodule : ddrwl_checker

bind ddrwl_core ddrwl_checker chk (.*);

// ===== verif/ddrwl_ctl_model.sv
`timescale 1ns/1ps
// ****
// controller model
// ****
module ddrwl_ctl_model (
  // launch clock
  input wire logic              core_clk,
  // dram side
  output logic                  ck,
  output logic                  cke,
  output logic                  odt,
  output ddrwl_pkg::ddrwl_cmd_t cmd_in,
  output logic [1:0]            dqs
);
  initial
  begin
    {ck, cke, odt, dqs} = 5'h08;
    cmd_in = '{4'hf, 3'h0, 16'h0};
    #7;
    forever #16 ck = ~ck;
  end
  task automatic mrs(input logic [2:0] ba, input logic [15:0] a);
    @(posedge core_clk);
    cmd_in <= '{ddrwl_pkg::CMD_MRS, ba, a};
    repeat (20) @(posedge core_clk);
    cmd_in <= '{4'h7, 3'h0, 16'h0};
    repeat (40) @(posedge core_clk);
  endtask : mrs
  // strobe rises mid-phase so the sampled ck level is unambiguous
  task automatic pulse(input int ln, input logic lv);
    do
      @(ck);
    while (ck !== lv);
    repeat (3) @(posedge core_clk);
    dqs[ln] <= 1'b1;
    repeat (8) @(posedge core_clk);
    dqs[ln] <= 1'b0;
    repeat (8) @(posedge core_clk);
    #1;
  endtask : pulse
endmodule : ddrwl_ctl_model

// ===== verif/dram_dll_freq_change_write_leveling_test.sv
`timescale 1ns/1ps
// ****
// bench
// ****
module dram_dll_freq_change_write_leveling_test;
  logic                   core_clk = 1'b0;
  logic                   rstn = 1'b0;
  logic                   psel = 1'b0;
  logic                   penable = 1'b0;
  logic                   pwrite = 1'b0;
  logic [7:0]             paddr = 8'h00;
  logic [31:0]            pwdata = 32'h0;
  logic [31:0]            prdata, rd;
  logic                   pready, pslverr, err, ck, cke, odt, rtt_dq_on;
  logic [1:0]             dqs;
  ddrwl_pkg::ddrwl_cmd_t  cmd_in;
  ddrwl_pkg::ddrwl_pins_t pins;
  int                     failures = 0;
  int                     tests_run = 0;
  always #2 core_clk = ~core_clk;
  ddrwl_core DUT (.*);
  ddrwl_ctl_model ctl (.*);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      failures++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do
      @(posedge core_clk);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wt();
    repeat (12) @(posedge core_clk);
    #1;
  endtask : wt
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : report_and_stop
  initial
  begin
    repeat (16) @(posedge core_clk);
    rstn <= 1'b1;
    apb(1'b0, ddrwl_pkg::OFF_STATUS, 32'h0);
    chk(rd & 32'h0f, 32'h0);
    apb(1'b0, 8'h40, 32'h0);
    chk({rd[30:0], err}, 32'h1);
    $display("test reset and map done");
    ctl.mrs(3'h1, 16'h0084);
    apb(1'b0, ddrwl_pkg::OFF_STATUS, 32'h0);
    chk(rd & 32'h01, 32'h1);
    @(posedge core_clk);
    ctl.odt <= 1'b1;
    wt();
    chk({29'h0, pins.rtt_dqs_on, rtt_dq_on}, 32'h6);
    for (int m = 0; m < 2; m++)
    begin
      apb(1'b1, ddrwl_pkg::OFF_CTRL, 32'(m));
      for (int i = 0; i < 4; i++)
      begin
        ctl.pulse(i / 2, 1'(i));
        chk({pins.dq_oe[i/2*8 +: 8], pins.dq_o[i/2*8 +: 8]},
            {24'hff, m ? {8{1'(i)}} : {7'h0, 1'(i)}});
      end
    end
    $display("test leveling samples done");
    ctl.mrs(3'h1, 16'h1084);
    wt();
    chk({16'h0, pins.dq_oe}, 32'h0);
    @(posedge core_clk);
    ctl.odt <= 1'b0;
    ctl.mrs(3'h1, 16'h0000);
    apb(1'b0, ddrwl_pkg::OFF_STATUS, 32'h0);
    chk(rd & 32'h09, 32'h0);
    $display("test leveling exit done");
    @(posedge core_clk);
    ctl.cke <= 1'b0;
    wt();
    @(posedge core_clk);
    ctl.odt <= 1'b1;
    wt();
    chk({31'h0, rtt_dq_on}, 32'h0);
    apb(1'b0, ddrwl_pkg::OFF_STATUS, 32'h0);
    chk(rd & 32'h04, 32'h4);
    ctl.odt <= 1'b0;
    ctl.cke <= 1'b1;
    $display("test power-down done");
    wt();
    ctl.mrs(3'h1, 16'h0001);
    @(posedge core_clk);
    ctl.cmd_in <= '{4'h1, 3'h0, 16'h0};
    ctl.cke <= 1'b0;
    wt();
    ctl.cmd_in <= '{4'h7, 3'h0, 16'h0};
    apb(1'b0, ddrwl_pkg::OFF_STATUS, 32'h0);
    chk(rd & 32'h12, 32'h02);
    ctl.cke <= 1'b1;
    wt();
    ctl.mrs(3'h1, 16'h0000);
    ctl.mrs(3'h0, 16'h0100);
    apb(1'b0, ddrwl_pkg::OFF_MR0, 32'h0);
    chk(rd, 32'h100);
    ctl.mrs(3'h0, 16'h0030);
    apb(1'b0, ddrwl_pkg::OFF_MR0, 32'h0);
    chk(rd, 32'h30);
    apb(1'b0, ddrwl_pkg::OFF_STATUS, 32'h0);
    chk(rd & 32'h12, 32'h10);
    $display("test dll switch done");
    report_and_stop();
  end
  initial
  begin
    #100000;
    failures++;
    report_and_stop();
  end
endmodule : dram_dll_freq_change_write_leveling_test
